// file: core/tsrb_pkg.sv
package tsrb_pkg;

  // ----------------------------------------------------------------
  // pointer addresses, reset values and the soft-reset command
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCAL_HI = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
  localparam logic [7:0] ADDR_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_ONESHOT = 8'h0F;
  localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
  localparam logic [7:0] ADDR_LOCAL_LO = 8'h15;
  localparam logic [7:0] ADDR_MAKER = 8'hFE;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] GCALL_SOFT_RESET = 8'h06;
  // arbitrary neutral identification value
  localparam logic [7:0] MAKER_CODE = 8'h3C;

  // ----------------------------------------------------------------
  // condition-flag bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_BUSY = 7;
  localparam int FLAG_LOCAL_OVER = 6;
  localparam int FLAG_LOCAL_UNDER = 5;
  localparam int FLAG_REMOTE_OVER = 4;
  localparam int FLAG_REMOTE_UNDER = 3;
  localparam int FLAG_OPEN = 2;
  localparam int FLAG_REMOTE_TRIP = 1;
  localparam int FLAG_LOCAL_TRIP = 0;

  // ----------------------------------------------------------------
  // settings table: read address, write address, reset, writable mask
  // ----------------------------------------------------------------
  localparam int NCFG = 17;
  localparam int IDX_SETTINGS = 0;
  localparam int IDX_RATE = 1;
  localparam int IDX_LOCAL_UPPER = 2;
  localparam int IDX_LOCAL_LOWER = 3;
  localparam int IDX_REMOTE_UPPER_MSB = 4;
  localparam int IDX_REMOTE_LOWER_MSB = 5;
  localparam int IDX_OFFSET_MSB = 6;
  localparam int IDX_OFFSET_LSB = 7;
  localparam int IDX_REMOTE_UPPER_LSB = 8;
  localparam int IDX_REMOTE_LOWER_LSB = 9;
  localparam int IDX_CHANNEL = 10;
  localparam int IDX_REMOTE_SHUTDOWN = 11;
  localparam int IDX_LOCAL_SHUTDOWN = 12;
  localparam int IDX_HYSTERESIS = 13;
  localparam int IDX_REPEAT = 14;
  localparam int IDX_IDEALITY = 15;
  localparam int IDX_FILTER = 16;

  localparam logic [7:0] CFG_RADDR [NCFG] = '{
    8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h16, 8'h19, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
  localparam logic [7:0] CFG_WADDR [NCFG] = '{
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h16, 8'h19, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
  localparam logic [7:0] CFG_RESET [NCFG] = '{
    8'h00, 8'h08, 8'h7F, 8'h80, 8'h7F, 8'h80, 8'h00, 8'h00, 8'hF0,
    8'h00, 8'h03, 8'h7F, 8'h7F, 8'h0A, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] CFG_MASK [NCFG] = '{
    8'hE4, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'hF0,
    8'hF0, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h0E, 8'hFF, 8'h03};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic done;
    logic busy;
    logic open_circuit;
    logic [11:0] local_result;
    logic [11:0] remote_result;
  } tsrb_conv_t;

  typedef enum logic [2:0] {
    LK_NONE = 3'b000,
    LK_LOCAL_LO = 3'b001,
    LK_LOCAL_HI = 3'b011,
    LK_REMOTE_LO = 3'b010,
    LK_REMOTE_HI = 3'b110
  } tsrb_lock_t;

endpackage : tsrb_pkg

// file: core/tsrb_regbank.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: local result split high byte, low nibble
// R2: remote result split high byte, low nibble
// R3: low four bits are the fraction
// R4: results read-only, rewritten per conversion
// R5: high read first locks low byte
// R6: low read first locks high byte
// R7: any other read releases the lock
// R8: host reads high then low byte
// R9: results zero after reset
// R10: pointer selects register, loaded each write
// R11: host loads pointer before reading
// R12: pointer resets to zero
// R13: flag register read-only at its address
// R14: flag bit seven shows conversion busy
// R15: bits six to three show limit trips
// R16: bit two shows remote open circuit
// R17: bits one, zero show shutdown trips
// R18: any write to trigger starts conversion
// R19: local limits, remote limit high bytes read/write at separate addresses
// R20: remote upper fraction in separate nibble
// R21: twelve-bit offset split, resets zero
// R22: filter in two low bits, resets zero
// R23: first write byte becomes pointer
// R24: flag read clears only absent conditions
// R25: general call 06 restores all, aborts
// R26: writes to read-only addresses ignored
module tsrb_regbank
  import tsrb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // byte transactions from the serial front end
  input wire logic ptr_load,
  input wire logic [7:0] ptr_byte,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_byte,
  input wire logic rd_strobe,
  input wire logic gcall_strobe,
  input wire logic [7:0] gcall_byte,
  output logic [7:0] rd_data_reg,
  output logic rd_valid_reg,
  // converter side
  input wire tsrb_pkg::tsrb_conv_t conv_in,
  output logic oneshot_reg,
  output logic abort_reg,
  output logic [7:0] flags_reg,
  output logic [NCFG-1:0][7:0] setting_reg
);
  import tsrb_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ptr_reg;
  logic [7:0] local_hi_reg;
  logic [7:0] local_lo_reg;
  logic [7:0] remote_hi_reg;
  logic [7:0] remote_lo_reg;
  tsrb_lock_t lock_reg;
  tsrb_lock_t lock_next;
  logic local_trip_reg;
  logic remote_trip_reg;
  logic [7:0] rd_next;
  logic soft_rst;
  logic flag_read;
  logic local_over;
  logic local_under;
  logic remote_over;
  logic remote_under;
  logic [11:0] local_full;
  logic [11:0] remote_full;
  logic [11:0] remote_upper;
  logic [11:0] remote_lower;
  logic [7:0] local_release;
  logic [7:0] remote_release;
  logic [7:0] loc_lim;
  logic [7:0] rem_lim;
  logic [7:0] hyst;

  // general-call software reset
  assign soft_rst = gcall_strobe && (gcall_byte == GCALL_SOFT_RESET); // [R25]
  assign flag_read = rd_strobe && (ptr_reg == ADDR_FLAGS);

  // ----------------------------------------------------------------
  // pointer
  // ----------------------------------------------------------------
  // loaded by the first byte of every write transaction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ptr_reg <= PTR_RESET; // [R12]
    end else if (clk_en) begin
      if (soft_rst) begin
        ptr_reg <= PTR_RESET; // [R25]
      end else if (ptr_load) begin
        ptr_reg <= ptr_byte; // [R10] [R23]
      end
    end
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  // one writable register per table entry; fixed bits keep reset value
  for (genvar i = 0; i < NCFG; i++) begin : g_cfg
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        setting_reg[i] <= CFG_RESET[i]; // [R21] [R22]
      end else if (clk_en) begin
        if (soft_rst) begin
          setting_reg[i] <= CFG_RESET[i]; // [R25]
        end else if (wr_strobe && (ptr_reg == CFG_WADDR[i])) begin
          // write address may differ from read address; others ignored [R26]
          setting_reg[i] <= (wr_byte & CFG_MASK[i]) | (CFG_RESET[i] & ~CFG_MASK[i]); // [R19] [R20] [R21] [R22]
        end
      end
    end
  end

  // one-shot trigger and abort pulses
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oneshot_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else if (clk_en) begin
      oneshot_reg <= wr_strobe && !soft_rst && (ptr_reg == ADDR_ONESHOT); // [R18]
      abort_reg <= soft_rst; // [R25]
    end
  end

  // ----------------------------------------------------------------
  // byte-coherence lock
  // ----------------------------------------------------------------
  // next lock state from which register is being read
  always_comb begin
    lock_next = lock_reg;
    if (rd_strobe) begin
      case (ptr_reg)
        ADDR_LOCAL_HI: begin
          lock_next = (lock_reg == LK_LOCAL_HI) ? LK_NONE : LK_LOCAL_LO; // [R5]
        end
        ADDR_LOCAL_LO: begin
          lock_next = (lock_reg == LK_LOCAL_LO) ? LK_NONE : LK_LOCAL_HI; // [R6]
        end
        ADDR_REMOTE_HI: begin
          lock_next = (lock_reg == LK_REMOTE_HI) ? LK_NONE : LK_REMOTE_LO; // [R5]
        end
        ADDR_REMOTE_LO: begin
          lock_next = (lock_reg == LK_REMOTE_LO) ? LK_NONE : LK_REMOTE_HI; // [R6]
        end
        default: begin
          lock_next = LK_NONE; // [R7]
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg <= LK_NONE;
    end else if (clk_en) begin
      lock_reg <= soft_rst ? LK_NONE : lock_next;
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  // converter rewrites each byte unless that byte is locked
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      local_hi_reg <= RESULT_RESET; // [R9]
      local_lo_reg <= RESULT_RESET;
      remote_hi_reg <= RESULT_RESET;
      remote_lo_reg <= RESULT_RESET;
    end else if (clk_en) begin
      if (soft_rst) begin
        local_hi_reg <= RESULT_RESET; // [R25]
        local_lo_reg <= RESULT_RESET;
        remote_hi_reg <= RESULT_RESET;
        remote_lo_reg <= RESULT_RESET;
      end else if (conv_in.done) begin
        if (lock_reg != LK_LOCAL_HI) begin
          local_hi_reg <= conv_in.local_result[11:4]; // [R1] [R3] [R4] [R6]
        end
        if (lock_reg != LK_LOCAL_LO) begin
          local_lo_reg <= {conv_in.local_result[3:0], 4'h0}; // [R1] [R3] [R5]
        end
        if (lock_reg != LK_REMOTE_HI) begin
          remote_hi_reg <= conv_in.remote_result[11:4]; // [R2] [R3] [R4] [R6]
        end
        if (lock_reg != LK_REMOTE_LO) begin
          remote_lo_reg <= {conv_in.remote_result[3:0], 4'h0}; // [R2] [R3] [R5]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // limit comparisons on the stored results
  // ----------------------------------------------------------------
  assign local_full = {local_hi_reg, local_lo_reg[7:4]};
  assign remote_full = {remote_hi_reg, remote_lo_reg[7:4]};
  assign remote_upper = {setting_reg[IDX_REMOTE_UPPER_MSB],
                         setting_reg[IDX_REMOTE_UPPER_LSB][7:4]};
  assign remote_lower = {setting_reg[IDX_REMOTE_LOWER_MSB],
                         setting_reg[IDX_REMOTE_LOWER_LSB][7:4]};
  assign local_over = local_full > {setting_reg[IDX_LOCAL_UPPER], 4'h0};
  assign local_under = local_full < {setting_reg[IDX_LOCAL_LOWER], 4'h0};
  assign remote_over = remote_full > remote_upper;
  assign remote_under = remote_full < remote_lower;

  // shutdown-trip release points: limit minus hysteresis, floored at zero
  assign loc_lim = setting_reg[IDX_LOCAL_SHUTDOWN];
  assign rem_lim = setting_reg[IDX_REMOTE_SHUTDOWN];
  assign hyst = setting_reg[IDX_HYSTERESIS];
  assign local_release = (loc_lim > hyst) ? 8'(loc_lim - hyst) : 8'h00;
  assign remote_release = (rem_lim > hyst) ? 8'(rem_lim - hyst) : 8'h00;

  // shutdown trips follow the temperature with hysteresis, no latching
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      local_trip_reg <= 1'b0;
      remote_trip_reg <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst) begin
        local_trip_reg <= 1'b0;
        remote_trip_reg <= 1'b0;
      end else begin
        if (local_hi_reg > loc_lim) begin
          local_trip_reg <= 1'b1; // [R17]
        end else if (local_hi_reg <= local_release) begin
          local_trip_reg <= 1'b0;
        end
        if (remote_hi_reg > rem_lim) begin
          remote_trip_reg <= 1'b1; // [R17]
        end else if (remote_hi_reg <= remote_release) begin
          remote_trip_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // condition flags
  // ----------------------------------------------------------------
  // sticky flags in bits six to two: a present condition always sets, so set wins over clear; busy and trip bits follow their sources
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= 8'h00;
    end else if (clk_en) begin
      if (soft_rst) begin
        flags_reg <= 8'h00; // [R25]
      end else begin
        flags_reg[FLAG_BUSY] <= conv_in.busy; // [R14]
        flags_reg[FLAG_LOCAL_OVER] <= local_over ||
          (flags_reg[FLAG_LOCAL_OVER] && !flag_read); // [R15] [R24]
        flags_reg[FLAG_LOCAL_UNDER] <= local_under ||
          (flags_reg[FLAG_LOCAL_UNDER] && !flag_read); // [R15] [R24]
        flags_reg[FLAG_REMOTE_OVER] <= remote_over ||
          (flags_reg[FLAG_REMOTE_OVER] && !flag_read); // [R15] [R24]
        flags_reg[FLAG_REMOTE_UNDER] <= remote_under ||
          (flags_reg[FLAG_REMOTE_UNDER] && !flag_read); // [R15] [R24]
        flags_reg[FLAG_OPEN] <= conv_in.open_circuit ||
          (flags_reg[FLAG_OPEN] && !flag_read); // [R16] [R24]
        flags_reg[FLAG_REMOTE_TRIP] <= remote_trip_reg; // [R17]
        flags_reg[FLAG_LOCAL_TRIP] <= local_trip_reg; // [R17]
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    rd_next = 8'h00;
    case (ptr_reg)
      ADDR_LOCAL_HI: rd_next = local_hi_reg;
      ADDR_LOCAL_LO: rd_next = local_lo_reg;
      ADDR_REMOTE_HI: rd_next = remote_hi_reg;
      ADDR_REMOTE_LO: rd_next = remote_lo_reg;
      ADDR_FLAGS: rd_next = flags_reg; // [R13]
      ADDR_MAKER: rd_next = MAKER_CODE;
      default: begin
        for (int i = 0; i < NCFG; i++) begin
          if (ptr_reg == CFG_RADDR[i]) begin
            rd_next = setting_reg[i]; // [R10] [R19]
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      rd_valid_reg <= rd_strobe;
      if (rd_strobe) begin
        rd_data_reg <= rd_next;
      end
    end
  end

endmodule : tsrb_regbank

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import tsrb_pkg::*;
  logic clock, reset_n, ptr_load, wr_strobe, rd_strobe, gcall_strobe, open_in, clk_en;
  logic rd_valid_reg, oneshot_reg, abort_reg;
  logic [7:0] ptr_byte, wr_byte, gcall_byte, rd_data_reg, flags_reg;
  logic [11:0] loc_in, rem_in;
  logic [NCFG-1:0][7:0] setting_reg;
  tsrb_conv_t conv_in;
  int n_fail, check_count, cyc;
  tsrb_regbank dut_u (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .ptr_load(ptr_load), .ptr_byte(ptr_byte), .wr_strobe(wr_strobe), .wr_byte(wr_byte),
    .rd_strobe(rd_strobe), .gcall_strobe(gcall_strobe), .gcall_byte(gcall_byte),
    .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .conv_in(conv_in),
    .oneshot_reg(oneshot_reg), .abort_reg(abort_reg), .flags_reg(flags_reg),
    .setting_reg(setting_reg));
  tsrb_conv_model #(.BUSY_CYC(8)) conv_u (.clock(clock), .reset_n(reset_n),
    .start(oneshot_reg), .stop(abort_reg), .open_in(open_in), .local_in(loc_in),
    .remote_in(rem_in), .conv(conv_in));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic pt(input logic [7:0] a);
    @(negedge clock);
    ptr_load = 1'b1;
    ptr_byte = a;
    @(negedge clock);
    ptr_load = 1'b0;
  endtask : pt
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pt(a);
    wr_strobe = 1'b1;
    wr_byte = d;
    @(negedge clock);
    wr_strobe = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    pt(a);
    rd_strobe = 1'b1;
    @(negedge clock);
    rd_strobe = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, rd_valid_reg});
    chk("rd_data", exp, rd_data_reg);
  endtask : rd
  task automatic conv(input logic [11:0] l, input logic [11:0] r);
    loc_in = l;
    rem_in = r;
    wr(ADDR_ONESHOT, 8'h5A);
    repeat (14) @(negedge clock);
  endtask : conv
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg;
    for (int i = 0; i < NCFG; i++) rd(CFG_RADDR[i], CFG_RESET[i]);
  endtask : t_cfg
  task automatic t_reset;
    // read with the pointer left at its reset value
    @(negedge clock);
    rd_strobe = 1'b1;
    @(negedge clock);
    rd_strobe = 1'b0;
    chk("rd_data", RESULT_RESET, rd_data_reg);
    t_cfg();
    rd(ADDR_LOCAL_HI, RESULT_RESET);
    rd(ADDR_REMOTE_HI, RESULT_RESET);
    rd(ADDR_REMOTE_LO, RESULT_RESET);
    rd(ADDR_LOCAL_LO, RESULT_RESET);
    rd(ADDR_MAKER, MAKER_CODE);
    rd(ADDR_ONESHOT, 8'h00);
    rd(8'h0B, 8'h00);
  endtask : t_reset
  task automatic t_rw;
    for (int i = 0; i < NCFG; i++) begin
      wr(CFG_WADDR[i], 8'hFF);
      rd(CFG_RADDR[i], CFG_MASK[i] | (CFG_RESET[i] & ~CFG_MASK[i]));
      chk("setting", CFG_MASK[i] | (CFG_RESET[i] & ~CFG_MASK[i]), setting_reg[i]);
    end
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_LOCAL_HI, 8'h00);
    @(negedge clock);
    gcall_strobe = 1'b1;
    gcall_byte = 8'h07;
    @(negedge clock);
    gcall_byte = GCALL_SOFT_RESET;
    @(negedge clock);
    gcall_strobe = 1'b0;
    t_cfg();
    // a frozen clock enable drops the write
    @(negedge clock);
    clk_en = 1'b0;
    wr(CFG_WADDR[IDX_LOCAL_UPPER], 8'h11);
    clk_en = 1'b1;
    rd(CFG_RADDR[IDX_LOCAL_UPPER], CFG_RESET[IDX_LOCAL_UPPER]);
  endtask : t_rw
  task automatic t_conv;
    loc_in = 12'hA51;
    rem_in = 12'h3C7;
    wr(ADDR_ONESHOT, 8'h00);
    rd(ADDR_FLAGS, 8'hA8);
    repeat (12) @(negedge clock);
    rd(ADDR_FLAGS, 8'h69);
    rd(ADDR_FLAGS, 8'h49);
    rd(ADDR_LOCAL_HI, 8'hA5);
    rd(ADDR_LOCAL_LO, 8'h10);
    rd(ADDR_REMOTE_HI, 8'h3C);
    rd(ADDR_REMOTE_LO, 8'h70);
    open_in = 1'b1;
    repeat (3) @(negedge clock);
    open_in = 1'b0;
    rd(ADDR_FLAGS, 8'h4D);
    rd(ADDR_FLAGS, 8'h49);
  endtask : t_conv
  task automatic t_lock;
    rd(ADDR_LOCAL_HI, 8'hA5);
    conv(12'h123, 12'h456);
    rd(ADDR_LOCAL_LO, 8'h10);
    rd(ADDR_LOCAL_HI, 8'h12);
    rd(ADDR_REMOTE_LO, 8'h60);
    conv(12'h789, 12'hABC);
    rd(ADDR_REMOTE_HI, 8'h45);
    rd(ADDR_LOCAL_HI, 8'h78);
    rd(8'h03, 8'h00);
    conv(12'hDEF, 12'h000);
    rd(ADDR_LOCAL_LO, 8'hF0);
  endtask : t_lock
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // main sequence
  initial begin
    {reset_n, ptr_load, wr_strobe, rd_strobe, gcall_strobe, open_in} = '0;
    {ptr_byte, wr_byte, gcall_byte, loc_in, rem_in} = '0;
    clk_en = 1'b1;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_rw();
    t_conv();
    t_lock();
    results();
  end
endmodule : tb_top

// file: tb/tsrb_conv_model.sv
`timescale 1ns/100ps
module tsrb_conv_model
  import tsrb_pkg::*;
#(
  parameter int BUSY_CYC = 8
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control from the bank
  input wire logic start,
  input wire logic stop,
  // values to report
  input wire logic open_in,
  input wire logic [11:0] local_in,
  input wire logic [11:0] remote_in,
  output tsrb_pkg::tsrb_conv_t conv
);
  import tsrb_pkg::*;
  int cnt;
  // busy for a fixed time, abort cancels
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) cnt <= 0;
    else if (stop) cnt <= 0;
    else if (start) cnt <= BUSY_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // results offered with the done pulse
  assign conv = '{done: cnt == 1, busy: cnt != 0, open_circuit: open_in,
    local_result: local_in, remote_result: remote_in};
endmodule : tsrb_conv_model

// file: tb/tsrb_regbank_props.sv
`timescale 1ns/100ps
module tsrb_regbank_props
  import tsrb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // register port
  input wire logic ptr_load,
  input wire logic [7:0] ptr_byte,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic gcall_strobe,
  input wire logic [7:0] gcall_byte,
  input wire logic [7:0] rd_data_reg,
  input wire logic rd_valid_reg,
  // converter side
  input wire tsrb_pkg::tsrb_conv_t conv_in,
  input wire logic oneshot_reg,
  input wire logic abort_reg,
  input wire logic [7:0] flags_reg,
  input wire logic [NCFG-1:0][7:0] setting_reg
);
  import tsrb_pkg::*;
  logic [7:0] ptr_q;
  logic srst;
  // software reset request seen this cycle
  assign srst = clk_en && gcall_strobe && (gcall_byte == GCALL_SOFT_RESET);
  // shadow of the pointer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ptr_q <= PTR_RESET;
    else if (srst) ptr_q <= PTR_RESET;
    else if (clk_en && ptr_load) ptr_q <= ptr_byte;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_rd;
    clk_en && rd_strobe && !srst;
  endsequence
  property p_rd_valid; s_rd |=> rd_valid_reg; endproperty
  property p_rd_hold;
    !(clk_en && rd_strobe) && !srst |=> !rd_valid_reg && $stable(rd_data_reg);
  endproperty
  property p_maker; s_rd ##0 (ptr_q == ADDR_MAKER) |=> rd_data_reg == MAKER_CODE; endproperty
  property p_os_rd; s_rd ##0 (ptr_q == ADDR_ONESHOT) |=> rd_data_reg == 8'h00; endproperty
  property p_os;
    clk_en && wr_strobe && !srst && ptr_q == ADDR_ONESHOT |=> oneshot_reg;
  endproperty
  property p_abort; srst |=> abort_reg ##1 !abort_reg; endproperty
  property p_ro_wr;
    clk_en && wr_strobe && !srst && ptr_q inside {8'h00, 8'h01, 8'h02, 8'h10, 8'h15, 8'hFE}
      |=> $stable(setting_reg);
  endproperty
  property p_busy; clk_en && !srst |=> flags_reg[FLAG_BUSY] == $past(conv_in.busy); endproperty
  property p_open; clk_en && !srst && conv_in.open_circuit |=> flags_reg[FLAG_OPEN]; endproperty
  property p_filter; setting_reg[IDX_FILTER][7:2] == 6'h00; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("no valid after read");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_maker: assert property (p_maker) else $error("maker code wrong");
  a_os_rd: assert property (p_os_rd) else $error("trigger read not zero");
  a_os: assert property (p_os) else $error("no conversion start");
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
  a_ro_wr: assert property (p_ro_wr) else $error("read-only write changed settings");
  a_busy: assert property (p_busy) else $error("busy flag wrong");
  a_open: assert property (p_open) else $error("open flag not set");
  a_filter: assert property (p_filter) else $error("filter spare bits set");
endmodule : tsrb_regbank_props

bind tsrb_regbank tsrb_regbank_props chk_u (.clock(clock), .reset_n(reset_n),
  .clk_en(clk_en), .ptr_load(ptr_load), .ptr_byte(ptr_byte), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .gcall_strobe(gcall_strobe), .gcall_byte(gcall_byte),
  .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .conv_in(conv_in),
  .oneshot_reg(oneshot_reg), .abort_reg(abort_reg), .flags_reg(flags_reg),
  .setting_reg(setting_reg));
